// *** hdl/serial_port_map.svh ***
// Register offsets, field positions and timing counts of the serial port
`ifndef SERIAL_PORT_MAP_SVH
`define SERIAL_PORT_MAP_SVH
`define CTRL_OFF 12'h098
`define DATA_OFF 12'h09C
`define PWR_OFF 12'h0A0
`define PWR_DOUBLE_BIT 7
`define PWR_FRAMING_BIT 6
`define CTRL_RESET 8'h00
`define M0_LAST 3'h5
`define M0_HALF 3'h2
`define OVS_LAST 4'hF
`define OVS_S1 4'h7
`define OVS_S2 4'h8
`define OVS_S3 4'h9
`define M0_BITS 4'h8
`define DATA8_BITS 4'h8
`define DATA9_BITS 4'h9
`define FRAME10_LAST 4'h9
`define FRAME11_LAST 4'hA
`define MODE_SHIFT 2'h0
`define MODE_UART8 2'h1
`define MODE_UART9F 2'h2
`define MODE_UART9V 2'h3
`endif

// *** hdl/serial_port_pkg.sv ***
// Types shared by the serial port design
package serial_port_pkg;
  typedef struct packed {
    logic upper_mode_bit;
    logic lower_mode_bit;
    logic multiprocessor_qualifier;
    logic receive_enable;
    logic transmit_ninth_bit;
    logic received_ninth_bit;
    logic transmit_done_flag;
    logic receive_done_flag;
  } ctrl_t;
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } rx_state_t;
endpackage : serial_port_pkg

// *** hdl/four_mode_serial_port.sv ***
// Four-mode serial port with APB register access
//
// Overview of operation
// - Mode 0: data on rx pin, clock on tx
// - Mode 0: eight bits, LSB first, no framing
// - Mode 0: fixed rate of core clock over six
// - Mode 0: shift clock out for both directions
// - Mode 1: start, eight data LSB first, stop
// - Mode 1 qualifier clear: stop bit into rb8
// - Mode 1 rate from timer overflow
// - Mode 2: start, eight data, ninth, stop
// - Modes 2/3: send transmit ninth bit
// - Modes 2/3: ninth bit to rb8, stop ignored
// - Mode 2 rate clock/16 or /32 by select
// - Mode 3 like mode 2, timer rate
// - Bit 7 is mode bit or framing error
// - Framing error sticky until software clears
// - Qualifier set: ninth bit 0 no receive-done
// - Mode 1 qualifier: need valid stop bit
// - Receive starts only while receive enable set
// - Mode 0 leaves rb8 undefined
// - Mode bits select the four modes
// - Sample at 16x, align on falling edge
// - Majority of samples 7,8,9; bad start aborts
// - Async load only if done clear and qualified
`timescale 1ns/1ps
`include "serial_port_map.svh"
module four_mode_serial_port
  import serial_port_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Baud source
  input wire logic i_timer_ovf,
  // Serial pins
  output logic o_txd,
  input wire logic i_rxd,
  output logic o_rxd_out,
  output logic o_rxd_oe
);
  ctrl_t ctrl_q;
  logic upper_mode_q, fe_q, double_q, framing_q, half_q;
  logic [7:0] tx_data_q, rx_buf_q;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  logic rx_s1_q, rx_s2_q, rx_s3_q, rx_lvl_q, rx_prev_q;
  // Mode 0 engine
  logic m0_act_q, m0_rx_q, m0_clk_q;
  logic [2:0] m0_cnt_q;
  logic [3:0] m0_bit_q;
  logic [7:0] m0_sh_q;
  // Async transmitter
  logic tx_act_q;
  logic [3:0] tx_ovs_q, tx_bit_q;
  logic [10:0] tx_sh_q;
  logic txd_q, rxd_out_q, rxd_oe_q;
  // Async receiver
  rx_state_t rx_st_q;
  logic [3:0] rx_ovs_q, rx_cnt_q;
  logic [2:0] samp_q;
  logic [8:0] rx_sh_q;
  logic [1:0] mode;
  logic nine, s_tick, acc, done, wr_ctrl, wr_data, wr_pwr;
  logic set_ti, set_ri, set_fe, load_rx, async_mode, vote, stop_ok, ninth_in;
  logic [7:0] load_data;
  logic load_ninth;

  function automatic logic [1:0] reg_sel(input logic [11:0] a);
    case (a)
      `CTRL_OFF: reg_sel = 2'h1;
      `DATA_OFF: reg_sel = 2'h2;
      `PWR_OFF: reg_sel = 2'h3;
      default: reg_sel = 2'h0;
    endcase
  endfunction : reg_sel

  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
  endfunction : maj3

  assign mode = {upper_mode_q, ctrl_q.lower_mode_bit};
  assign nine = mode[1];
  assign async_mode = (mode != `MODE_SHIFT);
  // Sixteen-times sample tick per mode
  always_comb begin
    case (mode)
      `MODE_UART9F: s_tick = double_q | half_q;
      default: s_tick = i_timer_ovf;
    endcase
  end

  // APB: one wait state, registered answer
  assign acc = i_psel & i_penable;
  assign done = acc & pready_q;
  assign wr_ctrl = done & i_pwrite & (reg_sel(i_paddr) == 2'h1);
  assign wr_data = done & i_pwrite & (reg_sel(i_paddr) == 2'h2);
  assign wr_pwr = done & i_pwrite & (reg_sel(i_paddr) == 2'h3);

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (i_clk_en) begin
      pready_q <= acc & ~pready_q;
      pslverr_q <= acc & ~pready_q & (reg_sel(i_paddr) == 2'h0);
      if (acc && !pready_q) begin
        case (reg_sel(i_paddr))
          2'h1: prdata_q <= {24'h00_0000, framing_q ? fe_q : upper_mode_q,
                             ctrl_q[6:0]};
          2'h2: prdata_q <= {24'h00_0000, rx_buf_q};
          2'h3: prdata_q <= {24'h00_0000, double_q, framing_q, 6'h00};
          default: prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control register and flags; hardware set wins over software clear
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q <= `CTRL_RESET;
      upper_mode_q <= 1'b0;
      fe_q <= 1'b0;
    end else if (i_clk_en) begin
      if (wr_ctrl) begin
        ctrl_q.lower_mode_bit <= i_pwdata[6];
        ctrl_q.multiprocessor_qualifier <= i_pwdata[5];
        ctrl_q.receive_enable <= i_pwdata[4];
        ctrl_q.transmit_ninth_bit <= i_pwdata[3];
        if (!framing_q) begin
          upper_mode_q <= i_pwdata[7];
        end
      end
      ctrl_q.transmit_done_flag <= set_ti |
          (wr_ctrl ? i_pwdata[1] : ctrl_q.transmit_done_flag);
      ctrl_q.receive_done_flag <= set_ri |
          (wr_ctrl ? i_pwdata[0] : ctrl_q.receive_done_flag);
      fe_q <= set_fe | ((wr_ctrl && framing_q) ? (fe_q & i_pwdata[7]) : fe_q);
      if (load_rx && async_mode) begin
        ctrl_q.received_ninth_bit <= load_ninth;
      end else if (wr_ctrl) begin
        ctrl_q.received_ninth_bit <= i_pwdata[2];
      end
    end
  end

  // Power control bits, data registers, rate halving
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      double_q <= 1'b0;
      framing_q <= 1'b0;
      tx_data_q <= 8'h00;
      rx_buf_q <= 8'h00;
      half_q <= 1'b0;
    end else if (i_clk_en) begin
      half_q <= ~half_q;
      if (wr_pwr) begin
        double_q <= i_pwdata[`PWR_DOUBLE_BIT];
        framing_q <= i_pwdata[`PWR_FRAMING_BIT];
      end
      if (wr_data) begin
        tx_data_q <= i_pwdata[7:0];
      end
      if (load_rx) begin
        rx_buf_q <= load_data;
      end
    end
  end

  // Receive pin synchroniser and filtered level
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_s3_q <= 1'b1;
      rx_lvl_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end else if (i_clk_en) begin
      rx_s1_q <= i_rxd;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
      if (rx_s2_q == rx_s3_q) begin
        rx_lvl_q <= rx_s3_q;
      end
      rx_prev_q <= rx_lvl_q;
    end
  end

  // Mode 0 shift engine at core clock over six
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      m0_act_q <= 1'b0;
      m0_rx_q <= 1'b0;
      m0_clk_q <= 1'b1;
      m0_cnt_q <= 3'h0;
      m0_bit_q <= 4'h0;
      m0_sh_q <= 8'h00;
    end else if (i_clk_en) begin
      if (!m0_act_q) begin
        m0_cnt_q <= 3'h0;
        m0_bit_q <= 4'h0;
        m0_clk_q <= 1'b1;
        if (mode == `MODE_SHIFT && wr_data) begin
          m0_act_q <= 1'b1;
          m0_rx_q <= 1'b0;
          m0_sh_q <= i_pwdata[7:0];
          m0_clk_q <= 1'b0;
        end else if (mode == `MODE_SHIFT && ctrl_q.receive_enable &&
                     !ctrl_q.receive_done_flag) begin
          m0_act_q <= 1'b1;
          m0_rx_q <= 1'b1;
          m0_clk_q <= 1'b0;
        end
      end else begin
        m0_cnt_q <= (m0_cnt_q == `M0_LAST) ? 3'h0 : m0_cnt_q + 3'h1;
        if (m0_cnt_q == `M0_HALF) begin
          m0_clk_q <= 1'b1;
          if (m0_rx_q) begin
            m0_sh_q <= {rx_lvl_q, m0_sh_q[7:1]};
          end
        end
        if (m0_cnt_q == `M0_LAST) begin
          m0_bit_q <= m0_bit_q + 4'h1;
          if (!m0_rx_q) begin
            m0_sh_q <= {1'b0, m0_sh_q[7:1]};
          end
          if (m0_bit_q == `M0_BITS - 4'h1) begin
            m0_act_q <= 1'b0;
            m0_clk_q <= 1'b1;
          end else begin
            m0_clk_q <= 1'b0;
          end
        end
      end
    end
  end

  // Async transmitter
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_act_q <= 1'b0;
      tx_ovs_q <= 4'h0;
      tx_bit_q <= 4'h0;
      tx_sh_q <= 11'h7FF;
    end else if (i_clk_en) begin
      if (!tx_act_q) begin
        tx_ovs_q <= 4'h0;
        tx_bit_q <= 4'h0;
        if (async_mode && wr_data) begin
          tx_act_q <= 1'b1;
          tx_sh_q <= nine ? {1'b1, ctrl_q.transmit_ninth_bit, i_pwdata[7:0], 1'b0}
                          : {2'b11, i_pwdata[7:0], 1'b0};
        end
      end else if (s_tick) begin
        tx_ovs_q <= tx_ovs_q + 4'h1;
        if (tx_ovs_q == `OVS_LAST) begin
          tx_sh_q <= {1'b1, tx_sh_q[10:1]};
          tx_bit_q <= tx_bit_q + 4'h1;
          if (tx_bit_q == (nine ? `FRAME11_LAST : `FRAME10_LAST)) begin
            tx_act_q <= 1'b0;
          end
        end
      end
    end
  end

  assign set_ti = (m0_act_q && !m0_rx_q && m0_cnt_q == `M0_LAST &&
                   m0_bit_q == `M0_BITS - 4'h1) ||
                  (tx_act_q && s_tick && tx_ovs_q == `OVS_LAST &&
                   tx_bit_q == (nine ? `FRAME11_LAST : `FRAME10_LAST) - 4'h1);

  // Pin drivers
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      txd_q <= 1'b1;
      rxd_out_q <= 1'b1;
      rxd_oe_q <= 1'b0;
    end else if (i_clk_en) begin
      if (mode == `MODE_SHIFT) begin
        txd_q <= m0_clk_q;
        rxd_oe_q <= m0_act_q & ~m0_rx_q;
        rxd_out_q <= m0_sh_q[0];
      end else begin
        txd_q <= tx_act_q ? tx_sh_q[0] : 1'b1;
        rxd_oe_q <= 1'b0;
        rxd_out_q <= 1'b1;
      end
    end
  end

  // Async receiver
  assign vote = maj3(samp_q);
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_st_q <= RX_IDLE;
      rx_ovs_q <= 4'h0;
      rx_cnt_q <= 4'h0;
      samp_q <= 3'h7;
      rx_sh_q <= 9'h000;
    end else if (i_clk_en) begin
      case (rx_st_q)
        RX_IDLE: begin
          rx_ovs_q <= 4'h0;
          rx_cnt_q <= 4'h0;
          if (async_mode && ctrl_q.receive_enable && rx_prev_q && !rx_lvl_q) begin
            rx_st_q <= RX_START;
          end
        end
        RX_START, RX_DATA, RX_STOP: begin
          if (s_tick) begin
            rx_ovs_q <= rx_ovs_q + 4'h1;
            if (rx_ovs_q == `OVS_S1) samp_q[0] <= rx_lvl_q;
            if (rx_ovs_q == `OVS_S2) samp_q[1] <= rx_lvl_q;
            if (rx_ovs_q == `OVS_S3) samp_q[2] <= rx_lvl_q;
            if (rx_st_q == RX_START && rx_ovs_q == `OVS_LAST) begin
              rx_st_q <= vote ? RX_IDLE : RX_DATA;
            end
            if (rx_st_q == RX_DATA && rx_ovs_q == `OVS_LAST) begin
              rx_sh_q <= {vote, rx_sh_q[8:1]};
              rx_cnt_q <= rx_cnt_q + 4'h1;
              if (rx_cnt_q == (nine ? `DATA9_BITS : `DATA8_BITS) - 4'h1) begin
                rx_st_q <= RX_STOP;
              end
            end
            if (rx_st_q == RX_STOP && rx_ovs_q == `OVS_S3) begin
              rx_st_q <= RX_IDLE;
            end
          end
          if (!async_mode) begin
            rx_st_q <= RX_IDLE;
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // Stop-bit decision uses the third sample taken this cycle
  assign stop_ok = maj3({rx_lvl_q, samp_q[1:0]});
  assign ninth_in = nine ? rx_sh_q[8] : stop_ok;
  assign set_fe = (rx_st_q == RX_STOP) && s_tick && rx_ovs_q == `OVS_S3 && !stop_ok;
  always_comb begin
    load_rx = 1'b0;
    load_data = 8'h00;
    load_ninth = ninth_in;
    if (rx_st_q == RX_STOP && s_tick && rx_ovs_q == `OVS_S3) begin
      load_rx = !ctrl_q.receive_done_flag &&
                (!ctrl_q.multiprocessor_qualifier || ninth_in);
      load_data = nine ? rx_sh_q[7:0] : rx_sh_q[8:1];
    end else if (m0_act_q && m0_rx_q && m0_cnt_q == `M0_LAST &&
                 m0_bit_q == `M0_BITS - 4'h1) begin
      load_rx = 1'b1;
      load_data = m0_sh_q;
    end
  end
  assign set_ri = load_rx;

  assign o_prdata = prdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_txd = txd_q;
  assign o_rxd_out = rxd_out_q;
  assign o_rxd_oe = rxd_oe_q;

  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  a_ti_sticky: assert property (i_clk_en && ctrl_q.transmit_done_flag && !wr_ctrl
      |=> ctrl_q.transmit_done_flag) else $error("transmit done dropped");
  a_ri_qualified: assert property (i_clk_en && load_rx && async_mode && nine &&
      ctrl_q.multiprocessor_qualifier |=> ctrl_q.received_ninth_bit)
      else $error("receive done with ninth bit zero");
  a_fe_sticky: assert property (i_clk_en && fe_q && !(wr_ctrl && framing_q)
      |=> fe_q) else $error("framing error lost");
  a_rx_needs_ren: assert property ($rose(rx_st_q == RX_START) |->
      $past(ctrl_q.receive_enable)) else $error("reception without enable");
  a_ri_only_clear: assert property (i_clk_en && async_mode && ctrl_q.receive_done_flag
      |=> rx_buf_q == $past(rx_buf_q))
      else $error("load while receive done set");
  a_m0_clk_idle: assert property (i_clk_en && mode == `MODE_SHIFT && !m0_act_q &&
      $past(!m0_act_q) |=> o_txd) else $error("shift clock not idle high");
  a_tx_start_low: assert property (i_clk_en && async_mode && !tx_act_q && wr_data
      ##1 i_clk_en |=> !o_txd) else $error("start bit not low");
  a_m1_stop_rb8: assert property (i_clk_en && load_rx && mode == `MODE_UART8
      |=> ctrl_q.received_ninth_bit == $past(stop_ok)) else $error("stop bit not in rb8");
  a_apb_pready_one: assert property (o_pready |=> !o_pready)
      else $error("pready held two cycles");

  c_tx_async: cover property (set_ti && async_mode);
  c_rx_m2: cover property (load_rx && mode == `MODE_UART9F);
  c_m0_rx: cover property (load_rx && mode == `MODE_SHIFT);
  c_fe_set: cover property (set_fe);
endmodule : four_mode_serial_port

// *** testbench/serial_node_model.sv ***
// Remote serial node: frame sender and line decoder
`timescale 1ns/1ps
module serial_node_model (
  // Clock
  input wire logic i_core_clk,
  // Lines from the port
  input wire logic i_txd,
  input wire logic i_data_wire,
  // Line to the port
  output logic o_rxd,
  // Decoded frame
  output logic [15:0] o_frame,
  output logic o_frame_vld
);
  initial begin
    o_rxd = 1'b1;
    o_frame = '0;
    o_frame_vld = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask : tick
  task automatic post(input logic [15:0] v);
    o_frame <= v;
    o_frame_vld <= 1'b1;
    tick(1);
    o_frame_vld <= 1'b0;
  endtask : post
  task automatic wait_lvl(input logic lv, inout int k);
    while (i_txd !== lv) begin
      tick(1);
      k++;
    end
  endtask : wait_lvl
  // Start low, data LSB first, ninth, stop; idle high after
  task automatic send(input logic [10:0] f, input int n, input int per);
    for (int i = 0; i < n; i++) begin
      o_rxd <= f[i];
      tick(per);
    end
    o_rxd <= 1'b1;
  endtask : send
  // Mid-bit sampling of an async frame, start bit in bit 0
  task automatic cap_async(input int n, input int per);
    logic [15:0] v;
    int k;
    v = '0;
    k = 0;
    wait_lvl(1'b0, k);
    tick(per / 2);
    for (int i = 0; i < n; i++) begin
      v[i] = i_txd;
      tick(per);
    end
    post(v);
  endtask : cap_async
  // Shift register: data on rising shift clock, period in upper byte
  task automatic cap_sync();
    logic [15:0] v;
    int k;
    v = '0;
    k = 0;
    for (int i = 0; i < 8; i++) begin
      wait_lvl(1'b0, k);
      wait_lvl(1'b1, k);
      v[i] = i_data_wire;
      if (i == 0) k = 0;
      if (i == 1) v[15:8] = 8'(k);
    end
    post(v);
  endtask : cap_sync
endmodule : serial_node_model

// *** testbench/tb_top.sv ***
// Self-checking bench for the four-mode serial port
`timescale 1ns/1ps
`include "serial_port_map.svh"
module tb_top;
  typedef struct {logic [31:0] v; logic [31:0] m; logic e;} rd_exp_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic ovf = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic [31:0] rdv;
  logic pready, pslverr, txd, rxd_out, rxd_oe, node_rxd, frame_vld;
  logic [15:0] frame;
  wire rxd_line;
  int error_cnt = 0;
  int cmp_count = 0;
  rd_exp_t rq[$];
  logic [15:0] fq[$];
  assign rxd_line = rxd_oe ? rxd_out : node_rxd;
  always #2.5 clk = ~clk;
  // Timer overflow every second cycle
  always @(posedge clk) ovf <= ~ovf;
  four_mode_serial_port dut_u (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_clk_en(1'b1),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_timer_ovf(ovf), .o_txd(txd), .i_rxd(rxd_line), .o_rxd_out(rxd_out),
    .o_rxd_oe(rxd_oe)
  );
  serial_node_model node_u (
    .i_core_clk(clk), .i_txd(txd), .i_data_wire(rxd_line), .o_rxd(node_rxd),
    .o_frame(frame), .o_frame_vld(frame_vld)
  );
  task automatic cmp_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_reg
  task automatic cmp_frame(input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("Error serial frame expected %h seen %h", e, g);
    end
  endtask : cmp_frame
  // Result watcher
  always @(posedge clk) begin
    rd_exp_t x;
    if (psel && penable && pready === 1'b1) begin
      x = rq.pop_front();
      cmp_reg("read data", x.v, prdata & x.m);
      cmp_reg("slave error", {31'h0, x.e}, {31'h0, pslverr});
    end
    if (frame_vld === 1'b1) cmp_frame(fq.pop_front(), frame);
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] ev, input logic [31:0] em, input logic ee);
    rq.push_back('{ev, em, ee});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, '0, '0, 1'b0);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, '0, e, 32'hFFFF_FFFF, 1'b0);
  endtask : rd
  // Start a transmission and decode it on the line
  task automatic tx_chk(input logic [7:0] d, input logic [15:0] e, input int n, input int per);
    fq.push_back(e);
    fork
      if (n == 0) node_u.cap_sync(); else node_u.cap_async(n, per);
      wr(`DATA_OFF, {24'h0, d});
    join
  endtask : tx_chk
  task automatic give_verdict();
    $display("Comparisons %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
  initial begin
    logic [7:0] d;
    logic [7:0] d2;
    void'($urandom(32'h6699));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`CTRL_OFF, `CTRL_RESET);
    rd(`PWR_OFF, 32'h0);
    apb(1'b0, 12'h0FC, '0, '0, 32'hFFFF_FFFF, 1'b1);
    apb(1'b1, 12'h0FC, 32'hFF, '0, '0, 1'b1);
    d = 8'($urandom);
    tx_chk(d, {8'h06, d}, 0, 0);
    rd(`CTRL_OFF, 32'h02);
    wr(`CTRL_OFF, 32'h00);
    wr(`CTRL_OFF, 32'h10);
    repeat (60) @(posedge clk);
    apb(1'b0, `CTRL_OFF, '0, 32'h11, 32'hFB, 1'b0);
    rd(`DATA_OFF, 32'hFF);
    wr(`CTRL_OFF, 32'h00);
    for (int i = 0; i < 2; i++) begin
      d = 8'($urandom);
      wr(`PWR_OFF, {24'h0, i[0], 7'h0});
      wr(`CTRL_OFF, {24'h0, 4'h8, i[0], 3'h0});
      tx_chk(d, {5'h0, 1'b1, i[0], d, 1'b0}, 11, 32 - 16 * i);
      rd(`CTRL_OFF, {24'h0, 4'h8, i[0], 3'h2});
    end
    wr(`PWR_OFF, 32'h0);
    wr(`CTRL_OFF, 32'h50);
    d = 8'($urandom);
    d2 = ~d;
    tx_chk(d, {6'h0, 1'b1, d, 1'b0}, 10, 32);
    node_u.send({2'b11, d, 1'b0}, 10, 32);
    rd(`CTRL_OFF, 32'h57);
    node_u.send({2'b11, d2, 1'b0}, 10, 32);
    rd(`DATA_OFF, {24'h0, d});
    wr(`CTRL_OFF, 32'h70);
    node_u.send({2'b00, d2, 1'b0}, 10, 32);
    rd(`CTRL_OFF, 32'h70);
    wr(`CTRL_OFF, 32'h40);
    node_u.send({2'b11, d2, 1'b0}, 10, 32);
    rd(`CTRL_OFF, 32'h40);
    wr(`CTRL_OFF, 32'hF0);
    node_u.send({2'b10, d2, 1'b0}, 11, 32);
    rd(`CTRL_OFF, 32'hF0);
    node_u.send({2'b11, d2, 1'b0}, 11, 32);
    rd(`CTRL_OFF, 32'hF5);
    rd(`DATA_OFF, {24'h0, d2});
    wr(`CTRL_OFF, 32'hD0);
    node_u.send({2'b01, d, 1'b0}, 11, 32);
    rd(`CTRL_OFF, 32'hD5);
    wr(`CTRL_OFF, 32'h50);
    wr(`PWR_OFF, 32'h40);
    wr(`CTRL_OFF, 32'h50);
    rd(`CTRL_OFF, 32'h50);
    node_u.send({2'b00, d, 1'b0}, 10, 32);
    rd(`CTRL_OFF, 32'hD1);
    wr(`CTRL_OFF, 32'hD0);
    node_u.send({2'b11, d, 1'b0}, 10, 32);
    rd(`CTRL_OFF, 32'hD5);
    wr(`CTRL_OFF, 32'h50);
    rd(`CTRL_OFF, 32'h50);
    give_verdict();
  end
endmodule : tb_top
